// ### e1_framer_status_interrupts.sv
/*
  Status, alarm criteria and interrupt logic of an E1 receive framer,
  with an AXI4-Lite register slave.
  Assumes the framer core delivers levels and one-cycle strobes that are
  synchronous to clock; one read and one write at most in flight.
*/
`timescale 1ns/1ps
module e1_framer_status_interrupts #(
  parameter int unsigned RAI_CLEAN_CYCLES = e1_status_pkg::RAI_CLEAN_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // global mode
  input wire logic line_standard_select,
  input wire logic unframed_option,
  // framer core
  input wire e1_status_pkg::framer_level_t level_in,
  input wire e1_status_pkg::framer_event_t event_in,
  // results
  output logic interrupt_request,
  output logic excess_crc_reframe,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [e1_status_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [e1_status_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  localparam int unsigned AW = e1_status_pkg::ADDR_W;
  localparam int unsigned AIS_W = $clog2(e1_status_pkg::AIS_PERIOD_BITS);
  localparam int unsigned RAI_W = $clog2(RAI_CLEAN_CYCLES + 1);

  // true when an aligned byte address hits the given register index
  function automatic logic addr_is(input logic [AW-1:0] a,
                                   input logic [9:0] idx);
    addr_is = (a[1:0] == 2'h0) && (a[AW-1:2] == idx);
  endfunction : addr_is

  function automatic logic addr_mapped(input logic [AW-1:0] a);
    addr_mapped = (a[1:0] == 2'h0) &&
      (a[AW-1:2] >= e1_status_pkg::IDX_FRAME_OPTIONS) &&
      (a[AW-1:2] <= e1_status_pkg::IDX_FRAMING_STATE);
  endfunction : addr_mapped

  logic block_rst;
  logic aw_full_q;
  logic [AW-1:0] aw_addr_q;
  logic w_full_q;
  logic [7:0] w_data_q;
  logic w_lane0_q;
  logic do_write;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic ar_take;
  logic [7:0] rd_mux;
  logic clr_framing;
  logic clr_alarm;
  logic clr_excess;
  logic reframe_en_q;
  logic criterion_q;
  logic [7:0] framing_en_q;
  logic [7:0] alarm_en_q;
  logic [AIS_W-1:0] ais_bit_cnt_q;
  logic [1:0] ais_zero_cnt_q;
  logic [2:0] zeros_sum;
  logic ais_period_end;
  logic period_low;
  logic ais_prev_low_q;
  logic all_ones_detect_q;
  logic [9:0] crc_cnt_q;
  logic excess_hit;
  logic excess_crc_error_status_q;
  logic excess_crc_reframe_q;
  logic a_bit_q;
  logic e_bit_q;
  logic [RAI_W-1:0] rai_timer_q;
  logic remote_alarm_clean_crc_state;
  logic [9:0] e_high_cnt_q;
  logic [2:0] febe_run_q;
  logic continuous_far_end_error_state;
  logic [2:0] sa7_hist_q;
  logic link_id_state;
  logic [7:0] framing_state;
  logic [7:0] alarm_state;
  logic [7:0] alarm_prev_q;
  logic [3:0] framing_prev_q;
  logic [7:0] framing_set;
  logic [7:0] alarm_set;
  logic [7:0] framing_ind_q;
  logic [7:0] alarm_ind_q;

  // option, enable, detector and indication registers are held reset outside framed E1 operation
  assign block_rst = !reset_n || !line_standard_select
                     || unframed_option; // RL5

  // write channel: address and data are taken in either order
  assign awready = !aw_full_q && !bvalid_q;
  assign wready = !w_full_q && !bvalid_q;
  assign do_write = aw_full_q && w_full_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= e1_status_pkg::RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      else if (do_write)
        aw_full_q <= 1'b0;
      if (wvalid && wready)
      begin
        w_full_q <= 1'b1;
        w_data_q <= wdata[7:0];
        w_lane0_q <= wstrb[0];
      end
      else if (do_write)
        w_full_q <= 1'b0;
      if (do_write)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= addr_mapped(aw_addr_q) ? e1_status_pkg::RESP_OKAY
                                          : e1_status_pkg::RESP_SLVERR;
      end
      else if (bready)
        bvalid_q <= 1'b0;
    end
  end

  // read channel: one outstanding read, answered on the next edge
  assign arready = !rvalid_q;
  assign ar_take = arvalid && arready;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  // reading an indication register clears it; reading the maintenance register clears its excess crc status
  assign clr_framing = ar_take
    && addr_is(araddr, e1_status_pkg::IDX_FRAMING_IND); // RL14
  assign clr_alarm = ar_take
    && addr_is(araddr, e1_status_pkg::IDX_ALARM_IND); // RL14
  assign clr_excess = ar_take
    && addr_is(araddr, e1_status_pkg::IDX_MAINT_OPTIONS); // RL4

  // read mux; everything reads zero while the block is held reset
  always_comb
  begin
    rd_mux = 8'h00;
    if (!block_rst)
    begin
      case (araddr[AW-1:2])
        e1_status_pkg::IDX_FRAME_OPTIONS:
          rd_mux[e1_status_pkg::REFRAME_EN_BIT] = reframe_en_q;
        e1_status_pkg::IDX_MAINT_OPTIONS:
        begin
          rd_mux[e1_status_pkg::CRITERION_BIT] = criterion_q;
          rd_mux[e1_status_pkg::EXCESS_CRC_BIT] = excess_crc_error_status_q;
        end
        e1_status_pkg::IDX_FRAMING_EN: rd_mux = framing_en_q;
        e1_status_pkg::IDX_ALARM_EN: rd_mux = alarm_en_q;
        e1_status_pkg::IDX_FRAMING_IND: rd_mux = framing_ind_q;
        e1_status_pkg::IDX_ALARM_IND: rd_mux = alarm_ind_q;
        e1_status_pkg::IDX_FRAMING_STATE: rd_mux = framing_state;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= e1_status_pkg::RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_mux};
      rresp_q <= addr_mapped(araddr) ? e1_status_pkg::RESP_OKAY
                                     : e1_status_pkg::RESP_SLVERR;
    end
    else if (rready)
      rvalid_q <= 1'b0;
  end

  // software-written controls; writes without byte lane 0 are ignored
  always_ff @(posedge clock)
  begin
    if (block_rst) // RL5
    begin
      reframe_en_q <= e1_status_pkg::OPTION_RESET;
      criterion_q <= e1_status_pkg::OPTION_RESET;
      framing_en_q <= e1_status_pkg::ENABLE_RESET;
      alarm_en_q <= e1_status_pkg::ENABLE_RESET;
    end
    else if (do_write && w_lane0_q)
    begin
      if (addr_is(aw_addr_q, e1_status_pkg::IDX_FRAME_OPTIONS))
        reframe_en_q <= w_data_q[e1_status_pkg::REFRAME_EN_BIT];
      if (addr_is(aw_addr_q, e1_status_pkg::IDX_MAINT_OPTIONS))
        criterion_q <= w_data_q[e1_status_pkg::CRITERION_BIT];
      if (addr_is(aw_addr_q, e1_status_pkg::IDX_FRAMING_EN))
        framing_en_q <= w_data_q;
      // reserved bit 4 is stored; its indication never sets anyway
      if (addr_is(aw_addr_q, e1_status_pkg::IDX_ALARM_EN))
        alarm_en_q <= w_data_q; // RL15
    end
  end

  // zero density over 512-bit periods; the zero count saturates at 3
  assign zeros_sum = {1'b0, ais_zero_cnt_q} + {2'h0, !event_in.line_bit};
  assign period_low = zeros_sum < 3'(e1_status_pkg::AIS_MIN_ZEROS);
  assign ais_period_end = event_in.line_bit_valid
    && ais_bit_cnt_q == AIS_W'(e1_status_pkg::AIS_PERIOD_BITS - 1);

  always_ff @(posedge clock)
  begin
    if (block_rst)
    begin
      ais_bit_cnt_q <= '0;
      ais_zero_cnt_q <= 2'h0;
      ais_prev_low_q <= 1'b0;
      all_ones_detect_q <= 1'b0;
    end
    else if (event_in.line_bit_valid)
    begin
      ais_bit_cnt_q <= ais_bit_cnt_q + AIS_W'(1);
      if (ais_period_end)
      begin
        ais_zero_cnt_q <= 2'h0;
        ais_prev_low_q <= period_low;
        if (!criterion_q)
        begin
          if (period_low && level_in.frame_loss_indication)
            all_ones_detect_q <= 1'b1; // RL1
          else if (!period_low)
            all_ones_detect_q <= 1'b0;
        end
        else if (period_low && ais_prev_low_q)
          all_ones_detect_q <= 1'b1; // RL2
        else if (!period_low && !ais_prev_low_q)
          all_ones_detect_q <= 1'b0; // RL2
      end
      else if (zeros_sum >= 3'(e1_status_pkg::AIS_MIN_ZEROS))
        ais_zero_cnt_q <= 2'(e1_status_pkg::AIS_MIN_ZEROS);
      else
        ais_zero_cnt_q <= zeros_sum[1:0];
    end
  end

  // crc errors per second; the hit fires once, on the 915th error
  assign excess_hit = event_in.crc_mismatch
    && crc_cnt_q == 10'(e1_status_pkg::CRC_EXCESS_LIMIT - 1); // RL3
  assign excess_crc_reframe = excess_crc_reframe_q;

  always_ff @(posedge clock)
  begin
    if (block_rst)
      crc_cnt_q <= 10'h000;
    else if (event_in.one_second)
      crc_cnt_q <= 10'h000;
    else if (event_in.crc_mismatch && crc_cnt_q != 10'h3ff)
      crc_cnt_q <= crc_cnt_q + 10'h001;
  end

  // a new hit in the reading cycle keeps the status set
  always_ff @(posedge clock)
  begin
    if (block_rst)
    begin
      excess_crc_error_status_q <= 1'b0;
      excess_crc_reframe_q <= 1'b0;
    end
    else
    begin
      if (excess_hit)
        excess_crc_error_status_q <= 1'b1; // RL3
      else if (clr_excess)
        excess_crc_error_status_q <= 1'b0; // RL4
      excess_crc_reframe_q <= excess_hit && reframe_en_q; // RL3
    end
  end

  // remote alarm with clean crc: the timer restarts on any break
  assign remote_alarm_clean_crc_state =
    rai_timer_q == RAI_W'(RAI_CLEAN_CYCLES); // RL19

  always_ff @(posedge clock)
  begin
    if (block_rst)
    begin
      a_bit_q <= 1'b0;
      e_bit_q <= 1'b1;
      rai_timer_q <= '0;
    end
    else
    begin
      if (event_in.a_bit_valid)
        a_bit_q <= event_in.a_bit;
      if (event_in.e_bit_valid)
        e_bit_q <= event_in.e_bit;
      if (!(a_bit_q && !e_bit_q))
        rai_timer_q <= '0;
      else if (!remote_alarm_clean_crc_state)
        rai_timer_q <= rai_timer_q + RAI_W'(1); // RL19
    end
  end

  // continuous far-end error: run of qualifying seconds, saturating
  assign continuous_far_end_error_state =
    febe_run_q == 3'(e1_status_pkg::FEBE_RUN_SECONDS); // RL20

  always_ff @(posedge clock)
  begin
    if (block_rst)
    begin
      e_high_cnt_q <= 10'h000;
      febe_run_q <= 3'h0;
    end
    else if (event_in.one_second)
    begin
      e_high_cnt_q <= 10'h000;
      if (e_high_cnt_q <= 10'(e1_status_pkg::FEBE_HIGH_LIMIT))
        febe_run_q <= 3'h0;
      else if (!continuous_far_end_error_state)
        febe_run_q <= febe_run_q + 3'h1; // RL20
    end
    else if (event_in.e_bit_valid && event_in.e_bit
             && e_high_cnt_q != 10'h3ff)
      e_high_cnt_q <= e_high_cnt_q + 10'h001;
  end

  // link identification: majority of zeros over the last three sa7 bits
  assign link_id_state = $countones(~sa7_hist_q)
    >= e1_status_pkg::LINK_ID_MIN_ZEROS; // RL21

  always_ff @(posedge clock)
  begin
    if (block_rst)
      sa7_hist_q <= 3'h7;
    else if (event_in.sa7_valid)
      sa7_hist_q <= {sa7_hist_q[1:0], event_in.sa7_bit};
  end

  // live status words
  assign framing_state = {level_in.interwork, // RL16
                          level_in.frame_loss, // RL17
                          level_in.sig_mf_loss,
                          level_in.crc_mf_loss,
                          level_in.offline_search, // RL18
                          remote_alarm_clean_crc_state,
                          continuous_far_end_error_state,
                          link_id_state};
  assign alarm_state = {level_in.remote_alarm_value,
                        level_in.remote_mf_alarm_value,
                        all_ones_detect_q, 1'b0,
                        level_in.red_alarm,
                        level_in.all_ones_alarm, 2'h0};

  // previous status, for change detection in either direction
  always_ff @(posedge clock)
  begin
    if (block_rst)
    begin
      framing_prev_q <= 4'h0;
      alarm_prev_q <= 8'h00;
    end
    else
    begin
      framing_prev_q <= framing_state[7:4];
      alarm_prev_q <= alarm_state;
    end
  end

  // set terms: changes, then single error events
  assign framing_set = {framing_state[7:4] ^ framing_prev_q, // RL11
                        event_in.align_move, // RL7
                        event_in.fas_error, // RL12
                        event_in.sig_mf_error,
                        event_in.crc_mf_error};
  assign alarm_set = ((alarm_state ^ alarm_prev_q)
                      & e1_status_pkg::ALARM_USED_MASK) // RL11
                     | {6'h00,
                        event_in.e_bit_valid && !event_in.e_bit, // RL10
                        event_in.crc_mismatch}; // RL10

  // sticky indications set regardless of enables; set wins over read
  always_ff @(posedge clock)
  begin
    if (block_rst)
    begin
      framing_ind_q <= e1_status_pkg::INDICATION_RESET;
      alarm_ind_q <= e1_status_pkg::INDICATION_RESET;
    end
    else
    begin
      framing_ind_q <= (clr_framing ? 8'h00 : framing_ind_q)
                       | framing_set; // RL13
      alarm_ind_q <= (clr_alarm ? 8'h00 : alarm_ind_q) | alarm_set; // RL13
    end
  end

  // one level output for all enabled indications
  assign interrupt_request = |(framing_ind_q & framing_en_q) // RL6 RL7 RL8
    | |(alarm_ind_q & alarm_en_q); // RL9 RL22

  default clocking cb @(posedge clock); endclocking
  default disable iff (block_rst);

  a_ais_lof_set: assert property ( // RL1
    !criterion_q && ais_period_end && period_low
    && level_in.frame_loss_indication |=> all_ones_detect_q)
    else $error("all-ones not declared on low-zero period in loss of frame");
  a_ais_two_periods: assert property ( // RL2
    criterion_q && ais_period_end && !period_low && !ais_prev_low_q
    |=> !all_ones_detect_q)
    else $error("all-ones not cleared after two normal periods");
  a_excess_crc_set: assert property ( // RL3
    excess_hit |=> excess_crc_error_status_q
    && (excess_crc_reframe == $past(reframe_en_q)))
    else $error("excess crc status or reframe wrong on 915th error");
  a_excess_read_clear: assert property ( // RL4
    clr_excess && !excess_hit |=> !excess_crc_error_status_q)
    else $error("excess crc status survived a read");
  a_held_reset: assert property ( // RL5
    @(posedge clock) disable iff (!reset_n)
    block_rst |=> framing_en_q == 8'h00 && alarm_ind_q == 8'h00
    && !interrupt_request)
    else $error("registers not held reset outside framed e1 mode");
  a_change_flag: assert property ( // RL11
    $changed(level_in.frame_loss) |=> framing_ind_q[6])
    else $error("frame loss change not flagged");
  a_poll_without_enable: assert property ( // RL13
    event_in.fas_error && framing_en_q == 8'h00 && alarm_en_q == 8'h00
    && !do_write |=> framing_ind_q[2] && !interrupt_request)
    else $error("error flag not set with enables off");
  a_read_drops_irq: assert property ( // RL14
    clr_framing && framing_set == 8'h00 && alarm_en_q == 8'h00
    && !do_write |=> framing_ind_q == 8'h00 && !interrupt_request)
    else $error("read did not clear indication and interrupt");
  a_irq_enabled_set: assert property ( // RL22
    event_in.crc_mismatch && alarm_en_q[0] && !do_write
    |=> interrupt_request [*1])
    else $error("enabled event did not raise the interrupt");

  c_ais_declared: cover property ($rose(all_ones_detect_q));
  c_excess_reframe: cover property (excess_crc_reframe);
  c_read_clear_irq: cover property (interrupt_request ##1 clr_framing);

endmodule : e1_framer_status_interrupts

// ### e1_status_pkg.sv
/*
  Constants, register map and carrier types for the E1 receive framer
  status and interrupt block.
  Assumes a 100 MHz system clock and 32-bit AXI4-Lite register access.

// Notes on behaviour
// RL1: criterion 0: all-ones on frame loss and a 512-bit period under 3 zeros
// RL2: criterion 1: set after 2 low-zero periods, clear after 2 normal periods
// RL3: 915 CRC errors within a second set excess status, optionally reframe
// RL4: excess CRC status returns to zero after its register is read
// RL5: all enables, indications and status held reset outside framed E1 mode
// RL6: interworking and alignment-loss changes interrupt if bits 7..4 enabled
// RL7: alignment position move interrupts when its enable is set
// RL8: frame and multiframe alignment errors interrupt when enabled
// RL9: alarm status changes interrupt, each through its own enable
// RL10: zero E bit sets far-end flag, CRC mismatch sets CRC flag, one event
// RL11: change flags set on both rising and falling status transitions
// RL12: error flags set if any error occurred since the last read
// RL13: indication bits set regardless of enables so software can poll
// RL14: reading an indication register clears it and its pending interrupt
// RL15: software keeps reserved alarm enable bit 4 at zero
// RL16: interworking status is one exactly while in interworking mode
// RL17: alignment loss status bits are one while that alignment is lost
// RL18: offline search status is one while offline framer is searching
// RL19: remote alarm with clean CRC after A high and E low for 10 ms
// RL20: continuous far-end error after 5 seconds of over 990 high E bits
// RL21: link identification when at least 2 of the last 3 Sa7 bits are zero
// RL22: interrupt output active while any enabled indication bit is set
*/
package e1_status_pkg;

  // register indices; byte address is four times the index
  localparam int unsigned ADDR_W = 12;
  localparam logic [9:0] IDX_FRAME_OPTIONS = 10'h090;
  localparam logic [9:0] IDX_MAINT_OPTIONS = 10'h091;
  localparam logic [9:0] IDX_FRAMING_EN = 10'h092;
  localparam logic [9:0] IDX_ALARM_EN = 10'h093;
  localparam logic [9:0] IDX_FRAMING_IND = 10'h094;
  localparam logic [9:0] IDX_ALARM_IND = 10'h095;
  localparam logic [9:0] IDX_FRAMING_STATE = 10'h096;

  // field positions
  localparam int unsigned REFRAME_EN_BIT = 1;
  localparam int unsigned CRITERION_BIT = 1;
  localparam int unsigned EXCESS_CRC_BIT = 0;
  localparam int unsigned ALARM_RESERVED_BIT = 4;
  localparam logic [7:0] ALARM_USED_MASK = 8'hef;

  // reset values
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] INDICATION_RESET = 8'h00;
  localparam logic OPTION_RESET = 1'b0;

  // detection figures
  localparam int unsigned AIS_PERIOD_BITS = 512;
  localparam int unsigned AIS_MIN_ZEROS = 3;
  localparam int unsigned CRC_EXCESS_LIMIT = 915;
  localparam int unsigned FEBE_HIGH_LIMIT = 990;
  localparam int unsigned FEBE_RUN_SECONDS = 5;
  localparam int unsigned LINK_ID_MIN_ZEROS = 2;

  // timing
  localparam int unsigned CLOCK_PERIOD_NS = 10;
  localparam int unsigned RAI_CLEAN_MS = 10;
  localparam int unsigned RAI_CLEAN_CYCLES =
    RAI_CLEAN_MS * 1000000 / CLOCK_PERIOD_NS;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // live levels from the framer core
  typedef struct packed {
    logic interwork;
    logic frame_loss;
    logic sig_mf_loss;
    logic crc_mf_loss;
    logic offline_search;
    logic remote_alarm_value;
    logic remote_mf_alarm_value;
    logic red_alarm;
    logic all_ones_alarm;
    logic frame_loss_indication;
  } framer_level_t;

  // one-cycle strobes from the framer core, with their sampled bits
  typedef struct packed {
    logic align_move;
    logic fas_error;
    logic sig_mf_error;
    logic crc_mf_error;
    logic crc_mismatch;
    logic one_second;
    logic line_bit_valid;
    logic line_bit;
    logic a_bit_valid;
    logic a_bit;
    logic e_bit_valid;
    logic e_bit;
    logic sa7_valid;
    logic sa7_bit;
  } framer_event_t;

endpackage : e1_status_pkg

// ### e1_line_model.sv
/*
  Far-end model: stands for the framer core fed by a remote line terminal.
  Assumes the bench sets level and strobe commands just after a rising
  edge; the model hands them to the block one edge later.
*/
`timescale 1ns/1ps
module e1_line_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // commands from the bench
  input wire e1_status_pkg::framer_level_t level_cmd,
  input wire e1_status_pkg::framer_event_t event_cmd,
  // towards the block
  output e1_status_pkg::framer_level_t level_in,
  output e1_status_pkg::framer_event_t event_in
);
  // levels are held, strobes last as long as their command; quiet while in reset
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      level_in <= '0;
      event_in <= '0;
    end
    else
    begin
      level_in <= level_cmd;
      event_in <= event_cmd;
    end
  end
endmodule : e1_line_model

// ### e1_framer_status_interrupts_tb_top.sv
/*
  Self-checking bench for the E1 status and interrupt block.
  Assumes the AXI4-Lite slave of the design and the far-end line model.
*/
`timescale 1ns/1ps
module e1_framer_status_interrupts_tb_top;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic unframed_option = 1'b0;
  logic line_standard_select = 1'b1;
  e1_status_pkg::framer_level_t level_cmd = '0;
  e1_status_pkg::framer_event_t event_cmd = '0;
  e1_status_pkg::framer_level_t level_in;
  e1_status_pkg::framer_event_t event_in;
  logic interrupt_request, excess_crc_reframe;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata, got;
  logic [1:0] bresp, rresp, resp;
  int fails = 0, n_compared = 0, cycles = 0;
  int n_reframe = 0;

  // small clean-count keeps the alarm timer short
  e1_framer_status_interrupts #(.RAI_CLEAN_CYCLES(20))
    e1_framer_status_interrupts_inst (.clock(clock), .reset_n(reset_n),
    .line_standard_select(line_standard_select),
    .unframed_option(unframed_option),
    .level_in(level_in), .event_in(event_in),
    .interrupt_request(interrupt_request),
    .excess_crc_reframe(excess_crc_reframe),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
  e1_line_model e1_line_model_inst (.clock(clock), .reset_n(reset_n),
    .level_cmd(level_cmd), .event_cmd(event_cmd),
    .level_in(level_in), .event_in(event_in));

  always #5 clock = ~clock;

  // the reframe output stands one cycle, so it is counted at every edge
  always @(posedge clock)
  begin
    if (excess_crc_reframe)
      n_reframe <= n_reframe + 1;
  end

  // hang guard, well above the roughly 1100 cycles the tests need
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails = fails + 1;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("BAD at %0t got %h want %h", $time, g, e);
    end
  endtask : chk

  // handshakes are judged at the rising edge that takes them, before the
  // design's registers move, and each request drops only after that edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!(bvalid && bready));
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!(rvalid && rready));
    got = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  // one-cycle strobe through the model, then let it settle
  task automatic pulse(input logic [13:0] e);
    @(posedge clock);
    event_cmd <= e;
    @(posedge clock);
    event_cmd <= '0;
    repeat (4) @(posedge clock);
    @(negedge clock);
  endtask : pulse

  task automatic t_reset;
    rd(12'h248);
    chk(got, 32'h0);
    rd(12'h24c);
    chk(got, 32'h0);
    rd(12'h3fc);
    chk({30'h0, resp}, {30'h0, e1_status_pkg::RESP_SLVERR});
    $display("t_reset done");
  endtask : t_reset

  // strobe bit 12 is the frame alignment error
  task automatic t_fas;
    wr(12'h248, 8'h04);
    pulse(14'h1000);
    chk({31'h0, interrupt_request}, 32'h1);
    rd(12'h250);
    chk(got, 32'h04);
    @(negedge clock);
    chk({31'h0, interrupt_request}, 32'h0);
    rd(12'h250);
    chk(got, 32'h0);
    $display("t_fas done");
  endtask : t_fas

  task automatic t_change;
    @(posedge clock);
    level_cmd.frame_loss <= 1'b1;
    pulse(14'h0000);
    chk({31'h0, interrupt_request}, 32'h0);
    rd(12'h258);
    chk(got, 32'h40);
    rd(12'h250);
    chk(got, 32'h40);
    @(posedge clock);
    level_cmd.frame_loss <= 1'b0;
    pulse(14'h0000);
    wr(12'h248, 8'h44);
    @(negedge clock);
    chk({31'h0, interrupt_request}, 32'h1);
    rd(12'h250);
    chk(got, 32'h40);
    $display("t_change done");
  endtask : t_change

  // bit 9 is the crc mismatch, bits 3 and 2 the E bit valid and value
  task automatic t_alarm;
    wr(12'h24c, 8'h01);
    pulse(14'h0200);
    chk({31'h0, interrupt_request}, 32'h1);
    pulse(14'h0008);
    rd(12'h254);
    chk(got, 32'h03);
    @(negedge clock);
    chk({31'h0, interrupt_request}, 32'h0);
    $display("t_alarm done");
  endtask : t_alarm

  // bits 1 and 0 carry the Sa7 valid and value; history starts at ones
  task automatic t_link;
    pulse(14'h0002);
    pulse(14'h0003);
    rd(12'h258);
    chk(got, 32'h00);
    pulse(14'h0002);
    rd(12'h258);
    chk(got, 32'h01);
    $display("t_link done");
  endtask : t_link

  task automatic t_block;
    wr(12'h24c, 8'hef);
    rd(12'h24c);
    chk(got, 32'hef);
    @(posedge clock);
    unframed_option <= 1'b1;
    repeat (2) @(posedge clock);
    unframed_option <= 1'b0;
    rd(12'h24c);
    chk(got, 32'h0);
    wr(12'h248, 8'h04);
    @(posedge clock);
    line_standard_select <= 1'b0;
    repeat (2) @(posedge clock);
    line_standard_select <= 1'b1;
    rd(12'h248);
    chk(got, 32'h0);
    pulse(14'h1000);
    chk({31'h0, interrupt_request}, 32'h0);
    rd(12'h250);
    chk(got, 32'h04);
    $display("t_block done");
  endtask : t_block

  // 914 back-to-back crc errors stay quiet, the 915th trips the status
  task automatic t_excess;
    wr(12'h240, 8'h02);
    @(posedge clock);
    event_cmd <= 14'h0200;
    repeat (914) @(posedge clock);
    event_cmd <= '0;
    rd(12'h244);
    chk(got, 32'h0);
    chk(n_reframe, 32'h0);
    pulse(14'h0200);
    chk(n_reframe, 32'h1);
    rd(12'h244);
    chk(got, 32'h01);
    rd(12'h244);
    chk(got, 32'h0);
    $display("t_excess done");
  endtask : t_excess

  // E bit low, then A high; the clean count is 20 cycles in this bench
  task automatic t_rai;
    pulse(14'h0008);
    pulse(14'h0030);
    rd(12'h258);
    chk(got, 32'h0);
    repeat (20) @(posedge clock);
    rd(12'h258);
    chk(got, 32'h04);
    $display("t_rai done");
  endtask : t_rai

  initial
  begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    t_reset();
    t_fas();
    t_change();
    t_alarm();
    t_link();
    t_block();
    t_excess();
    t_rai();
    stop_test();
  end
endmodule : e1_framer_status_interrupts_tb_top
